//--- fepc_codec.sv
// 100 Mbit coding sublayer: 4B/5B, scrambling, NRZI/MLT-3 and receive framing
`timescale 1ns/1ps
`default_nettype none
module fepc_codec (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  mac_txd,
    input  wire logic        mac_tx_en,
    input  wire logic        mac_tx_er,
    input  wire logic        mac_tx_valid,
    output logic             mac_tx_ready,
    output logic [3:0]       mac_rxd,
    output logic             mac_rx_dv,
    output logic             mac_rx_er,
    output logic             mac_crs,
    output logic             mac_rx_stb,
    output logic             rx_clk_recovered,
    input  wire logic [4:0]  phy_addr,
    input  wire logic        line_signal_detected,
    input  wire logic        link_fail,
    input  wire logic [5:0]  adc_sample,
    input  wire logic [7:0]  rx_phase_en,
    input  wire logic [2:0]  dsp_phase_sel,
    output logic [2:0]       adc_gain,
    output logic [1:0]       tx_mlt3,
    output logic             tx_nrzi,
    output logic             desc_locked
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_K    = 4'h2,
        TX_DATA = 4'h4,
        TX_R    = 4'h8
    } fepc_tx_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h1,
        RX_SSD2 = 3'h2,
        RX_DATA = 3'h4
    } fepc_rx_t;

    typedef struct packed {
        logic [23:0] s1;
        logic [23:0] s2;
        logic [1:0]  st_cnt;
        logic        seeded;
        fepc_tx_t    tx_state;
        logic [2:0]  tx_bitc;
        logic [4:0]  tx_sh;
        logic        nrzi;
        logic [1:0]  mlt_ph;
        logic [1:0]  mlt3;
        logic [1:0]  rx_lvl;
        logic [10:0] khist;
        logic [4:0]  run;
        logic        locked;
        logic [11:0] wd;
        logic [14:0] hist;
        logic [2:0]  rx_bitc;
        fepc_rx_t    rx_state;
        logic [3:0]  rxd;
        logic        dv;
        logic        er;
        logic        crs;
        logic        stb;
        logic [1:0]  refc;
        logic [2:0]  gain;
        logic [7:0]  gain_cnt;
        logic        gain_seen;
    } fepc_core_t;

    fepc_core_t  r_reg;
    fepc_core_t  r_next;
    logic [4:0]  s_addr;
    logic        s_sig;
    logic        s_lf;
    logic [5:0]  s_adc;
    logic [7:0]  s_ph;
    logic [2:0]  s_sel;
    logic        sym_en;
    logic        tx_key;
    logic        tx_line_bit;
    logic        q_valid;
    logic        q_pop;
    logic [5:0]  q_data;
    logic [1:0]  lvl;
    logic        code;
    logic        kpred;
    logic        db;
    logic [14:0] hist_n;
    logic [4:0]  p_grp;
    logic [4:0]  g_grp;
    logic [4:0]  p_dec;
    logic [4:0]  grp;
    logic [5:0]  a_abs;
    logic        wd_hit;
    logic        abort;
    logic        bad_ssd;

    assign s_addr = r_reg.s2[23:19];
    assign s_sig = r_reg.s2[18];
    assign s_lf = r_reg.s2[17];
    assign s_adc = r_reg.s2[16:11];
    assign s_ph = r_reg.s2[10:3];
    assign s_sel = r_reg.s2[2:0];
    assign sym_en = s_ph[s_sel];

    assign mac_rxd = r_reg.rxd;
    assign mac_rx_dv = r_reg.dv;
    assign mac_rx_er = r_reg.er;
    assign mac_crs = r_reg.crs;
    assign mac_rx_stb = r_reg.stb;
    assign rx_clk_recovered = s_sig;
    assign adc_gain = r_reg.gain;
    assign tx_mlt3 = r_reg.mlt3;
    assign tx_nrzi = r_reg.nrzi;
    assign desc_locked = r_reg.locked;

    fepc_fifo #(
        .W (fepc_pkg::TXQ_W),
        .D (fepc_pkg::FIFO_DEPTH)
    ) u_txq (
        .clk       (sys_clk),
        .nrst      (nrst),
        .in_valid  (mac_tx_valid),
        .in_ready  (mac_tx_ready),
        .in_data   ({mac_tx_er, mac_tx_en, mac_txd}),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (q_data)
    );

    fepc_lfsr u_scr (
        .clk  (sys_clk),
        .nrst (nrst),
        .en   (r_reg.seeded),
        .load (!r_reg.seeded && (r_reg.st_cnt == 2'h3)),
        .seed ({1'b1, s_addr, ~s_addr}),
        .key  (tx_key)
    );

    assign tx_line_bit = r_reg.tx_sh[4] ^ tx_key;

    always_comb begin
        r_next = r_reg;
        r_next.s1 = {phy_addr, line_signal_detected, link_fail, adc_sample,
                     rx_phase_en, dsp_phase_sel};
        r_next.s2 = r_reg.s1;
        q_pop = 1'b0;
        grp = fepc_pkg::CG_IDLE;
        if (!r_reg.seeded) begin
            r_next.st_cnt = r_reg.st_cnt + 2'h1;
            r_next.seeded = (r_reg.st_cnt == 2'h3);
        end

        // Transmit: one code bit per cycle, new group every fifth bit
        r_next.nrzi = r_reg.nrzi ^ tx_line_bit;
        if (tx_line_bit) begin
            r_next.mlt_ph = r_reg.mlt_ph + 2'h1;
        end
        r_next.mlt3 = r_next.mlt_ph[0] ? (r_next.mlt_ph[1] ? fepc_pkg::LVL_NEG
                                                           : fepc_pkg::LVL_POS)
                                       : fepc_pkg::LVL_ZERO;
        r_next.tx_sh = {r_reg.tx_sh[3:0], 1'b0};
        r_next.tx_bitc = r_reg.tx_bitc + 3'h1;
        if (r_reg.tx_bitc == fepc_pkg::GRP_LAST) begin
            r_next.tx_bitc = 3'h0;
            unique case (r_reg.tx_state)
                TX_IDLE: begin
                    q_pop = q_valid && r_reg.seeded;
                    if (q_pop && q_data[4]) begin
                        grp = fepc_pkg::CG_J;
                        r_next.tx_state = TX_K;
                    end
                end
                TX_K: begin
                    q_pop = q_valid && q_data[4];
                    grp = fepc_pkg::CG_K;
                    r_next.tx_state = TX_DATA;
                end
                TX_DATA: begin
                    if (q_valid && q_data[4]) begin
                        q_pop = 1'b1;
                        grp = q_data[5] ? fepc_pkg::CG_H : fepc_pkg::enc(q_data[3:0]);
                    end else begin
                        grp = fepc_pkg::CG_T;
                        r_next.tx_state = TX_R;
                    end
                end
                TX_R: begin
                    grp = fepc_pkg::CG_R;
                    r_next.tx_state = TX_IDLE;
                end
                default: begin
                    r_next.tx_state = TX_IDLE;
                end
            endcase
            r_next.tx_sh = grp;
        end

        // Receive: MLT-3 level, descrambling and framing
        lvl = ($signed(s_adc) > fepc_pkg::MLT_THR) ? fepc_pkg::LVL_POS :
              ($signed(s_adc) < fepc_pkg::MLT_THR_N) ? fepc_pkg::LVL_NEG : fepc_pkg::LVL_ZERO;
        code = (lvl != r_reg.rx_lvl);
        kpred = r_reg.khist[fepc_pkg::TAP_A] ^ r_reg.khist[fepc_pkg::TAP_B];
        db = code ^ kpred;
        hist_n = {r_reg.hist[13:0], db};
        p_grp = hist_n[9:5];
        g_grp = hist_n[4:0];
        p_dec = fepc_pkg::dec(p_grp);
        a_abs = s_adc[5] ? 6'(6'h00 - s_adc) : s_adc;
        bad_ssd = ((hist_n[14:5] == {fepc_pkg::CG_IDLE, fepc_pkg::CG_J}) &&
                   (g_grp != fepc_pkg::CG_K)) ||
                  ((hist_n[9:0] == {fepc_pkg::CG_J, fepc_pkg::CG_K}) &&
                   (hist_n[14:10] != fepc_pkg::CG_IDLE));
        wd_hit = r_reg.locked && (r_reg.wd == fepc_pkg::IDLE_WIN_LAST);
        abort = !s_sig || s_lf || !r_reg.locked || wd_hit;
        r_next.stb = 1'b0;
        r_next.refc = r_reg.refc + 2'h1;
        if (r_reg.refc == fepc_pkg::REF_DIV_LAST) begin
            r_next.refc = 2'h0;
        end

        if (r_reg.locked) begin
            r_next.wd = r_reg.wd + 12'h001;
        end
        if (sym_en) begin
            r_next.rx_lvl = lvl;
            r_next.rx_bitc = (r_reg.rx_bitc == fepc_pkg::GRP_LAST) ? 3'h0
                                                                   : r_reg.rx_bitc + 3'h1;
            if (a_abs >= fepc_pkg::GAIN_HI) begin
                r_next.gain_cnt = 8'h00;
                r_next.gain_seen = 1'b0;
                if (r_reg.gain != 3'h0) begin
                    r_next.gain = r_reg.gain - 3'h1;
                end
            end else begin
                r_next.gain_cnt = r_reg.gain_cnt + 8'h01;
                r_next.gain_seen = r_reg.gain_seen || (a_abs >= fepc_pkg::GAIN_LO);
                if (r_reg.gain_cnt == fepc_pkg::GAIN_WIN_LAST) begin
                    r_next.gain_seen = 1'b0;
                    if (!r_reg.gain_seen && (r_reg.gain != fepc_pkg::GAIN_MAX)) begin
                        r_next.gain = r_reg.gain + 3'h1;
                    end
                end
            end
            if (!r_reg.locked) begin
                r_next.khist = {r_reg.khist[9:0], ~code};
                r_next.run = (kpred == ~code) ? r_reg.run + 5'h01 : 5'h00;
                if (r_reg.run == fepc_pkg::LOCK_RUN) begin
                    r_next.locked = 1'b1;
                    r_next.wd = 12'h000;
                end
            end else begin
                r_next.khist = {r_reg.khist[9:0], kpred};
                r_next.hist = hist_n;
                if (g_grp == fepc_pkg::CG_IDLE) begin
                    r_next.wd = 12'h000;
                end
            end
        end
        if (wd_hit || !s_sig) begin
            r_next.locked = 1'b0;
            r_next.run = 5'h00;
            r_next.wd = 12'h000;
        end

        if (!s_sig) begin
            r_next.stb = (r_reg.refc == fepc_pkg::REF_DIV_LAST);
            if (r_next.stb) begin
                r_next.er = 1'b0;
            end
        end else if (sym_en && (r_reg.rx_bitc == fepc_pkg::GRP_LAST)) begin
            r_next.stb = 1'b1;
            if (r_reg.rx_state == RX_IDLE) begin
                r_next.er = 1'b0;
            end
        end

        if (abort) begin
            r_next.rx_state = RX_IDLE;
            r_next.dv = 1'b0;
            r_next.crs = 1'b0;
            r_next.er = 1'b0;
        end else if (sym_en) begin
            unique case (r_reg.rx_state)
                RX_IDLE: begin
                    if (hist_n == {fepc_pkg::CG_IDLE, fepc_pkg::CG_J, fepc_pkg::CG_K}) begin
                        r_next.rx_bitc = 3'h0;
                        r_next.rx_state = RX_SSD2;
                        r_next.rxd = fepc_pkg::NIB_PRE;
                        r_next.dv = 1'b1;
                        r_next.crs = 1'b1;
                        r_next.er = 1'b0;
                        r_next.stb = 1'b1;
                    end else if (bad_ssd) begin
                        r_next.rxd = fepc_pkg::NIB_BAD_SSD;
                        r_next.er = 1'b1;
                        r_next.stb = 1'b1;
                    end
                end
                RX_SSD2: begin
                    if (r_reg.rx_bitc == fepc_pkg::GRP_LAST) begin
                        r_next.rxd = fepc_pkg::NIB_PRE;
                        r_next.rx_state = RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (r_reg.rx_bitc == fepc_pkg::GRP_LAST) begin
                        if (p_dec[4]) begin
                            r_next.rxd = p_dec[3:0];
                            r_next.er = 1'b0;
                        end else if (((p_grp == fepc_pkg::CG_T) && (g_grp == fepc_pkg::CG_R)) ||
                                     ((p_grp == fepc_pkg::CG_IDLE) &&
                                      (g_grp == fepc_pkg::CG_IDLE))) begin
                            r_next.rx_state = RX_IDLE;
                            r_next.dv = 1'b0;
                            r_next.crs = 1'b0;
                            r_next.er = 1'b0;
                        end else begin
                            r_next.er = 1'b1;
                        end
                    end
                end
                default: begin
                    r_next.rx_state = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.tx_state <= TX_IDLE;
            r_reg.rx_state <= RX_IDLE;
            r_reg.tx_sh <= fepc_pkg::CG_IDLE;
            r_reg.gain <= fepc_pkg::GAIN_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    a_tx_legal_group: assert property (@(posedge sys_clk) disable iff (!nrst)
        (r_reg.tx_bitc == fepc_pkg::GRP_LAST) |=> fepc_pkg::tx_legal(r_reg.tx_sh))
        else $error("illegal code-group loaded for transmit");
    a_nrzi_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
        !tx_line_bit |=> $stable(tx_nrzi) && $stable(tx_mlt3))
        else $error("line output moved on a zero code bit");
    a_mlt3_step: assert property (@(posedge sys_clk) disable iff (!nrst)
        tx_line_bit |=> (tx_mlt3 != $past(tx_mlt3)) && (tx_nrzi != $past(tx_nrzi)))
        else $error("line output held on a one code bit");
    a_idle_window: assert property (@(posedge sys_clk) disable iff (!nrst)
        wd_hit |=> !desc_locked && !mac_rx_dv)
        else $error("idle window expiry did not abort reception");
    a_dv_first_nib: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(mac_rx_dv) |-> (mac_rxd == fepc_pkg::NIB_PRE) && mac_rx_stb && mac_crs
        ##[1:5] (mac_rx_stb && (mac_rxd == fepc_pkg::NIB_PRE)))
        else $error("frame did not open with two preamble nibbles");
    a_signal_loss: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!s_sig || s_lf) |=> !mac_rx_dv && !mac_crs)
        else $error("data valid survived signal or link loss");
    a_bad_ssd_out: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mac_rx_er && !mac_crs) |-> (mac_rxd == fepc_pkg::NIB_BAD_SSD) && !mac_rx_dv)
        else $error("bad start pair not reported as 1110");
    a_ref_strobe: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!s_sig && (r_reg.refc == fepc_pkg::REF_DIV_LAST)) ##1 !s_sig |-> mac_rx_stb ##1 !mac_rx_stb)
        else $error("reference nibble strobe missing");
endmodule
`default_nettype wire

//--- fepc_pkg.sv
// Shared constants, code tables and helpers for the fast ethernet coding block
package fepc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int SYM_MHZ = 125;
    localparam logic [2:0] GRP_LAST = 3'h4;
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_H = 5'h04;
    localparam logic [3:0] NIB_PRE = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD = 4'hE;
    localparam int LFSR_W = 11;
    localparam int TAP_A = 8;
    localparam int TAP_B = 10;
    localparam logic [4:0] LOCK_RUN = 5'h1E;
    localparam int IDLE_WIN_BYTES = 4000;
    localparam int IDLE_WIN_US = 40;
    localparam int IDLE_WIN_CYC = IDLE_WIN_US * CLK_MHZ;
    localparam logic [11:0] IDLE_WIN_LAST = 12'(IDLE_WIN_CYC - 1);
    localparam int REF_NIB_MHZ = 25;
    localparam logic [1:0] REF_DIV_LAST = 2'(CLK_MHZ / REF_NIB_MHZ - 1);
    localparam int FIFO_DEPTH = 8;
    localparam int TXQ_W = 6;
    localparam int ADC_W = 6;
    localparam int PHASES = 8;
    localparam logic signed [5:0] MLT_THR = 6'sh0A;
    localparam logic signed [5:0] MLT_THR_N = -6'sh0A;
    localparam logic [1:0] LVL_ZERO = 2'h0;
    localparam logic [1:0] LVL_POS = 2'h1;
    localparam logic [1:0] LVL_NEG = 2'h3;
    localparam logic [5:0] GAIN_HI = 6'h1E;
    localparam logic [5:0] GAIN_LO = 6'h10;
    localparam logic [2:0] GAIN_MAX = 3'h7;
    localparam logic [2:0] GAIN_RST = 3'h4;
    localparam logic [7:0] GAIN_WIN_LAST = 8'hFF;

    function automatic logic [4:0] enc(input logic [3:0] n);
        logic [4:0] c;
        unique case (n)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction

    // Returns {hit, nibble}; hit is low for every non-data group
    function automatic logic [4:0] dec(input logic [4:0] cg);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (enc(4'(i)) == cg) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic tx_legal(input logic [4:0] cg);
        logic [4:0] d;
        d = dec(cg);
        return d[4] || (cg inside {CG_IDLE, CG_J, CG_K, CG_T, CG_R, CG_H});
    endfunction
endpackage

//--- fepc_lfsr.sv
// Transmit scrambler key generator with address-derived seed
`timescale 1ns/1ps
`default_nettype none
module fepc_lfsr (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       en,
    input  wire logic                       load,
    input  wire logic [fepc_pkg::LFSR_W-1:0] seed,
    output logic                            key
);
    typedef struct packed {
        logic [fepc_pkg::LFSR_W-1:0] s;
    } fepc_lfsr_t;

    fepc_lfsr_t r_reg;
    fepc_lfsr_t r_next;

    assign key = r_reg.s[fepc_pkg::TAP_A] ^ r_reg.s[fepc_pkg::TAP_B];

    always_comb begin
        r_next = r_reg;
        if (load) begin
            r_next.s = seed;
        end else if (en) begin
            r_next.s = {r_reg.s[fepc_pkg::LFSR_W-2:0], key};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

//--- fepc_fifo.sv
// Small valid/ready FIFO for the transmit nibble path
`timescale 1ns/1ps
`default_nettype none
module fepc_fifo #(
    parameter int W = 6,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } fepc_fifo_t;

    fepc_fifo_t r_reg;
    fepc_fifo_t r_next;
    logic       full;
    logic       empty;

    assign full = (r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
    assign empty = (r_reg.wp == r_reg.rp);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = r_reg.mem[r_reg.rp[AW-1:0]];

    always_comb begin
        r_next = r_reg;
        if (in_valid && !full) begin
            r_next.mem[r_reg.wp[AW-1:0]] = in_data;
            r_next.wp = r_reg.wp + (AW+1)'(1);
        end
        if (out_ready && !empty) begin
            r_next.rp = r_reg.rp + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

//--- fepc_line_model.sv
// Far-end line model: loops the three-level transmit output back as samples
`timescale 1ns/1ps
`default_nettype none
module fepc_line_model (
    input  wire logic       clk,
    input  wire logic [1:0] lvl,
    output logic [5:0]      smp
);
    initial smp = 6'h00;
    // One signed sample per symbol, +20 / 0 / -20
    always @(posedge clk) begin
        smp <= (lvl == fepc_pkg::LVL_POS) ? 6'h14 : (lvl == fepc_pkg::LVL_NEG) ? 6'h2C : 6'h00;
    end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench: MAC driver, line loopback and receive monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [3:0] mac_txd = 4'h0;
    logic       mac_tx_en = 1'b0;
    logic       mac_tx_er = 1'b0;
    logic       mac_tx_valid = 1'b0;
    logic [4:0] phy_addr = 5'h00;
    logic [2:0] dsp_phase_sel = 3'h0;
    logic       line_signal_detected = 1'b0;
    logic       link_fail = 1'b0;
    logic       chk_on = 1'b0;
    logic       dv_d = 1'b0;
    logic       unl = 1'b0;
    logic [7:0] rx_phase_en = 8'hFF;
    logic [1:0] mlt_d = 2'h0;
    logic       nrzi_d = 1'b0;
    logic [3:0] mac_rxd;
    logic [2:0] adc_gain;
    logic [1:0] tx_mlt3;
    logic [5:0] adc_sample;
    logic       mac_tx_ready, mac_rx_dv, mac_rx_er, mac_crs, mac_rx_stb;
    logic       rx_clk_recovered, tx_nrzi, desc_locked;
    logic [4:0] exp_q[$];
    int         n_fail = 0;
    int         num_checks = 0;
    int         n_stb = 0;

    fepc_codec fepc_codec_inst (.sys_clk, .nrst, .mac_txd, .mac_tx_en, .mac_tx_er,
        .mac_tx_valid, .mac_tx_ready, .mac_rxd, .mac_rx_dv, .mac_rx_er, .mac_crs,
        .mac_rx_stb, .rx_clk_recovered, .phy_addr, .line_signal_detected, .link_fail,
        .adc_sample, .rx_phase_en, .dsp_phase_sel, .adc_gain, .tx_mlt3,
        .tx_nrzi, .desc_locked);
    fepc_line_model fepc_line_model_inst (.clk(sys_clk), .lvl(tx_mlt3), .smp(adc_sample));

    initial forever #5 sys_clk = ~sys_clk;

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmp5(input logic [4:0] g, input logic [4:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e);
        cmp5({4'h0, g}, {4'h0, e});
    endtask

    task automatic wait_sig(ref logic s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && s !== v; k++) begin
            @(posedge sys_clk);
            #1;
        end
        if (s !== v) begin
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic send(input logic [3:0] n, input logic e, input logic r);
        int k;
        mac_txd = n;
        mac_tx_en = e;
        mac_tx_er = r;
        mac_tx_valid = 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge sys_clk);
            if (mac_tx_ready === 1'b1) break;
        end
        #1;
        if (k == 200) begin
            n_fail++;
            wrap_up();
        end
    endtask

    // Preamble pair goes out as the start pair and must come back as 5, 5
    task automatic frame(input int len, input int er_at, input logic rnd);
        logic [3:0] d;
        send(4'h5, 1'b1, 1'b0);
        send(4'h5, 1'b1, 1'b0);
        exp_q.push_back(5'h05);
        exp_q.push_back(5'h05);
        for (int i = 0; i < len; i++) begin
            d = rnd ? 4'($urandom) : 4'h1;
            send(d, 1'b1, i == er_at);
            exp_q.push_back(i == er_at ? 5'h10 : {1'b0, d});
        end
        send(4'h0, 1'b0, 1'b0);
        mac_tx_valid = 1'b0;
    endtask

    task automatic settle;
        for (int k = 0; k < 400 && exp_q.size() > 0; k++) begin
            @(posedge sys_clk);
            #1;
        end
        cmp5(5'(exp_q.size()), 5'h00);
        wait_sig(mac_rx_dv, 1'b0, 100);
        cmp1(mac_crs, 1'b0);
    endtask

    task automatic gap(input logic [4:0] e);
        int k;
        wait_sig(mac_rx_stb, 1'b1, 60);
        k = 0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
        end while (mac_rx_stb !== 1'b1 && k < 60);
        cmp5(5'(k), e);
    endtask

    always @(posedge sys_clk) begin
        dv_d <= mac_rx_dv;
        mlt_d <= tx_mlt3;
        nrzi_d <= tx_nrzi;
        if (chk_on) cmp1(tx_nrzi ^ nrzi_d, tx_mlt3 != mlt_d);
        if (desc_locked === 1'b0) unl <= 1'b1;
        if (chk_on && mac_rx_dv === 1'b1 && dv_d !== 1'b1) cmp1(mac_rx_stb, 1'b1);
        if (chk_on && mac_rx_stb === 1'b1 && mac_rx_dv === 1'b1) begin
            // A nibble arriving with nothing expected always fails
            if (exp_q.size() == 0) cmp5(5'h00, 5'h1F);
            else if (exp_q[0][4]) cmp1(mac_rx_er, exp_q.pop_front() != 5'h00);
            else cmp5({mac_rx_er, mac_rxd}, exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(25092));
        phy_addr = 5'($urandom);
        dsp_phase_sel = 3'($urandom);
        repeat (2) @(posedge sys_clk);
        #1;
        cmp1(mac_tx_ready, 1'b1);
        cmp5({2'h0, adc_gain}, 5'h04);
        nrst = 1'b1;
        gap(5'h04);
        cmp1(rx_clk_recovered, 1'b0);
        line_signal_detected = 1'b1;
        wait_sig(desc_locked, 1'b1, 3000);
        gap(5'h05);
        cmp1(rx_clk_recovered, 1'b1);
        chk_on = 1'b1;
        frame(12, 99, 1'b1);
        settle();
        frame(8, 3, 1'b1);
        settle();
        mac_tx_valid = 1'b1;
        wait_sig(mac_tx_ready, 1'b0, 40);
        cmp1(mac_tx_ready, 1'b0);
        mac_tx_valid = 1'b0;
        repeat (50) @(posedge sys_clk);
        #1;
        cmp1(mac_tx_ready, 1'b1);
        chk_on = 1'b0;
        frame(30, 99, 1'b1);
        wait_sig(mac_rx_dv, 1'b1, 100);
        link_fail = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        cmp1(mac_rx_dv, 1'b0);
        link_fail = 1'b0;
        repeat (300) @(posedge sys_clk);
        #1;
        wait_sig(desc_locked, 1'b1, 3000);
        unl = 1'b0;
        // A frame without idle groups longer than the watchdog window
        frame(850, 9999, 1'b0);
        cmp1(unl, 1'b1);
        wait_sig(desc_locked, 1'b1, 3000);
        cmp5({2'h0, adc_gain}, 5'h04);
        // Deselecting the chosen phase must stop line-derived strobes
        rx_phase_en = ~(8'h01 << dsp_phase_sel);
        repeat (4) @(posedge sys_clk);
        #1;
        repeat (20) begin
            @(posedge sys_clk);
            #1;
            if (mac_rx_stb === 1'b1) n_stb++;
        end
        cmp5(5'(n_stb), 5'h00);
        wrap_up();
    end

    initial begin
        #1000000;
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
